// ### hdl/cdrl_map.svh
// Register offsets, field positions, reset values and counts of the rate/lock block
`ifndef CDRL_MAP_SVH
`define CDRL_MAP_SVH
// ==================== Register offsets
`define CDRL_OFF_CTRL 8'h0A
`define CDRL_OFF_RATE 8'h2F
`define CDRL_OFF_REF 8'h36
`define CDRL_OFF_G0LO 8'h60
`define CDRL_OFF_G0HI 8'h61
`define CDRL_OFF_G1LO 8'h62
`define CDRL_OFF_G1HI 8'h63
`define CDRL_OFF_TOL 8'h64
`define CDRL_OFF_EQMAN 8'h2C
`define CDRL_OFF_EQCTL 8'h2D
`define CDRL_OFF_CHSEL 8'hFF
// ==================== Per-channel storage indices
`define CDRL_NREG 10
`define CDRL_IDX_CTRL 4'h0
`define CDRL_IDX_RATE 4'h1
`define CDRL_IDX_REF 4'h2
`define CDRL_IDX_G0LO 4'h3
`define CDRL_IDX_G0HI 4'h4
`define CDRL_IDX_G1LO 4'h5
`define CDRL_IDX_G1HI 4'h6
`define CDRL_IDX_TOL 4'h7
`define CDRL_IDX_EQCTL 4'h8
`define CDRL_IDX_EQMAN 4'h9
// ==================== Field positions
`define CDRL_CTRL_RST 3:2
`define CDRL_RATE_NIB 7:4
`define CDRL_RATE_FLD_OFF 1
`define CDRL_REF_MODE 5:4
`define CDRL_REF_MODE3 2'h3
`define CDRL_CNT_MANUAL 7
`define CDRL_EQ_MANUAL 0
`define CDRL_EQ_FORCE 4
`define CDRL_EQ_FDIV 6:5
// ==================== Reset values
`define CDRL_RST_RATE 8'h02
`define CDRL_RST_REF 8'h30
`define CDRL_ROW_RST {56'h0, `CDRL_RST_REF, `CDRL_RST_RATE, 8'h00}
// ==================== Default expected counts, oscillator GHz times 1280
`define CDRL_CNT_9G8304 15'h3127
`define CDRL_CNT_12G288 15'h3D71
`define CDRL_CNT_12G5 15'h3E80
`define CDRL_CNT_10G3125 15'h3390
`define CDRL_CNT_10G0 15'h3200
// ==================== Coarse tuning windows and limits
`define CDRL_CAP_BASE_3 5'h18
`define CDRL_CAP_BASE_4 5'h04
`define CDRL_CAP_BASE_AB 5'h00
`define CDRL_CAP_BASE_CF 5'h0C
`define CDRL_CAP_SPAN 5'h07
`define CDRL_CAP_LAST 5'h1F
`define CDRL_FAIL_LIMIT 3'h4
`define CDRL_ERR_MAX 15'h7FFF
`endif

// ### hdl/cdrl_pkg.sv
// Types shared by the rate/lock block
`include "cdrl_map.svh"
package cdrl_pkg;
    typedef logic [`CDRL_NREG-1:0][7:0] cdrl_row_t;
    typedef enum {ST_IDLE, ST_FETCH, ST_EVAL, ST_CFETCH, ST_CINIT, ST_CREQ, ST_CWAIT} cdrl_fsm_t;
    typedef struct packed {
        cdrl_row_t [3:0] arr;
        logic [7:0] rd_data;
        cdrl_row_t row;
    } cdrl_mem_state_t;
    typedef struct packed {
        cdrl_fsm_t fsm;
        logic [7:0] chsel;
        logic [3:0] hold, cal_pend, eq_auto, grp, lock;
        logic [3:0][2:0] fail;
        logic [3:0][1:0] div;
        logic [3:0][4:0] cap;
        logic [3:0][7:0] eq;
        logic [1:0] mch, row_ch, tdiv;
        logic [14:0] mcount, best_err;
        logic [4:0] code, last, best_code;
        logic rd_pend, rd_chsel, rd_bad, rvalid, tune_req;
        logic [7:0] rdata;
    } cdrl_state_t;
endpackage : cdrl_pkg

// ### hdl/cdrl_mem_if.sv
// Carrier between the control logic and the per-channel register store
`timescale 1ns/1ns
`default_nettype none
interface cdrl_mem_if;
    import cdrl_pkg::*;
    logic wr_en;
    logic [1:0] wr_ch, rd_ch, row_ch;
    logic [3:0] wr_idx, rd_idx;
    logic [7:0] wr_data, rd_data;
    cdrl_row_t row;
    modport ctrl(output wr_en, wr_ch, wr_idx, wr_data, rd_ch, rd_idx, row_ch,
                 input rd_data, row);
    modport mem(input wr_en, wr_ch, wr_idx, wr_data, rd_ch, rd_idx, row_ch,
                output rd_data, row);
endinterface : cdrl_mem_if
`default_nettype wire

// ### hdl/cdrl_cfg_mem.sv
// Per-channel register store with a byte read port and a whole-row read port
`timescale 1ns/1ns
`default_nettype none
`include "cdrl_map.svh"
module cdrl_cfg_mem (
    input wire logic mclk,
    input wire logic rst,
    cdrl_mem_if.mem m
);
    import cdrl_pkg::*;
    cdrl_mem_state_t st, nx;
    // ==================== Write and registered reads
    always_comb begin
        nx = st;
        if (m.wr_en) begin
            nx.arr[m.wr_ch][m.wr_idx] = m.wr_data;
        end
        nx.rd_data = st.arr[m.rd_ch][m.rd_idx];
        nx.row = st.arr[m.row_ch];
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '{arr: {4{cdrl_row_t'(`CDRL_ROW_RST)}}, rd_data: 8'h00, row: '0};
        end else begin
            st <= nx;
        end
    end
    assign m.rd_data = st.rd_data;
    assign m.row = st.row;
endmodule : cdrl_cfg_mem
`default_nettype wire

// ### hdl/cdrl_top.sv
// Rate, divider and coarse tuning control with frequency-lock checking, four channels
`timescale 1ns/1ns
`default_nettype none
`include "cdrl_map.svh"
module cdrl_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [3:0] pll_locked,
    input wire logic meas_valid,
    input wire logic [1:0] meas_ch,
    input wire logic [14:0] meas_count,
    input wire logic eq_adj_valid,
    input wire logic [1:0] eq_adj_ch,
    input wire logic eq_adj_up,
    output logic tune_req,
    output logic [1:0] tune_ch,
    output logic [4:0] tune_code,
    output logic [1:0] tune_div,
    output logic [3:0][1:0] div_sel,
    output logic [3:0][4:0] cap_code,
    output logic [3:0][7:0] eq_boost,
    output logic [3:0] lock
);
    import cdrl_pkg::*;
    localparam cdrl_state_t ST_RST = '{fsm: ST_IDLE, cal_pend: 4'hF, eq_auto: 4'hF, default: '0};
    cdrl_mem_if m();
    cdrl_state_t st, nx;

    // ==================== Helper functions
    // address to storage index, bit 4 marks a per-channel register
    function automatic logic [4:0] reg_index(input logic [7:0] a);
        case (a)
            `CDRL_OFF_CTRL: return {1'b1, `CDRL_IDX_CTRL};
            `CDRL_OFF_RATE: return {1'b1, `CDRL_IDX_RATE};
            `CDRL_OFF_REF: return {1'b1, `CDRL_IDX_REF};
            `CDRL_OFF_G0LO: return {1'b1, `CDRL_IDX_G0LO};
            `CDRL_OFF_G0HI: return {1'b1, `CDRL_IDX_G0HI};
            `CDRL_OFF_G1LO: return {1'b1, `CDRL_IDX_G1LO};
            `CDRL_OFF_G1HI: return {1'b1, `CDRL_IDX_G1HI};
            `CDRL_OFF_TOL: return {1'b1, `CDRL_IDX_TOL};
            `CDRL_OFF_EQCTL: return {1'b1, `CDRL_IDX_EQCTL};
            `CDRL_OFF_EQMAN: return {1'b1, `CDRL_IDX_EQMAN};
            default: return 5'h00;
        endcase
    endfunction : reg_index
    function automatic logic [3:0] div_mask(input logic [3:0] nib, input logic grp);
        case (nib)
            4'h3: return 4'b0111;
            4'h4: return 4'b0110;
            4'h6: return 4'b1111;
            4'hA: return 4'b0010;
            4'hB: return 4'b0110;
            4'hC: return 4'b0001;
            4'hF: return grp ? 4'b0001 : 4'b1000;
            default: return 4'b0000;
        endcase
    endfunction : div_mask
    // default counts from the oscillator rate of each standard
    function automatic logic [14:0] def_count(input logic [3:0] nib, input logic grp);
        case (nib)
            4'h3: return `CDRL_CNT_9G8304;
            4'h4: return `CDRL_CNT_12G288;
            4'hA, 4'hB: return `CDRL_CNT_12G5;
            4'hC: return `CDRL_CNT_10G3125;
            4'hF: return grp ? `CDRL_CNT_10G3125 : `CDRL_CNT_10G0;
            default: return `CDRL_CNT_10G0;
        endcase
    endfunction : def_count
    // start of the coarse tuning window
    function automatic logic [4:0] cap_base(input logic [3:0] nib);
        case (nib)
            4'h3: return `CDRL_CAP_BASE_3;
            4'h4: return `CDRL_CAP_BASE_4;
            4'hA, 4'hB: return `CDRL_CAP_BASE_AB;
            4'hC, 4'hF: return `CDRL_CAP_BASE_CF;
            default: return 5'h00;
        endcase
    endfunction : cap_base
    // Next allowed divider after the current one, wrapping
    function automatic logic [1:0] pick_div(input logic [3:0] mask, input logic [1:0] cur);
        logic [1:0] r;
        logic [1:0] j;
        logic done;
        r = cur;
        done = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            j = cur + 2'(i);
            if (!done && mask[j]) begin
                r = j;
                done = 1'b1;
            end
        end
        return r;
    endfunction : pick_div
    // forced or unit divider outside the standards
    function automatic logic [1:0] sel_div(input cdrl_row_t r, input logic g, input logic [1:0] cur);
        logic [3:0] mask;
        mask = div_mask(r[`CDRL_IDX_RATE][`CDRL_RATE_NIB], g);
        if (mask != 4'h0) return pick_div(mask, cur);
        return r[`CDRL_IDX_EQCTL][`CDRL_EQ_FORCE] ? r[`CDRL_IDX_EQCTL][`CDRL_EQ_FDIV] : 2'h0;
    endfunction : sel_div
    // manual count or default of the rate code
    function automatic logic [14:0] exp_count(input cdrl_row_t r, input logic g);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = g ? r[`CDRL_IDX_G1LO] : r[`CDRL_IDX_G0LO];
        hi = g ? r[`CDRL_IDX_G1HI] : r[`CDRL_IDX_G0HI];
        if (hi[`CDRL_CNT_MANUAL]) return {hi[6:0], lo};
        return def_count(r[`CDRL_IDX_RATE][`CDRL_RATE_NIB], g);
    endfunction : exp_count
    function automatic logic [14:0] abs_diff(input logic [14:0] a, input logic [14:0] b);
        return (a > b) ? a - b : b - a;
    endfunction : abs_diff
    // raise the first stage below top, or lower the last stage above zero
    function automatic logic [7:0] eq_step(input logic [7:0] e, input logic up);
        logic [7:0] r;
        logic done;
        r = e;
        done = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (up && !done && r[2*i+:2] != 2'h3) begin
                r[2*i+:2] = r[2*i+:2] + 2'h1;
                done = 1'b1;
            end
        end
        for (int i = 3; i >= 0; i--) begin
            if (!up && !done && r[2*i+:2] != 2'h0) begin
                r[2*i+:2] = r[2*i+:2] - 2'h1;
                done = 1'b1;
            end
        end
        return r;
    endfunction : eq_step

    // ==================== Register store
    cdrl_cfg_mem u_mem (.mclk(mclk), .rst(rst), .m(m.mem));
    // Decoded index of the current access
    logic [4:0] acc_idx;
    assign acc_idx = reg_index(reg_addr);
    // accesses reach the selected channel only
    assign m.wr_en = reg_wr & acc_idx[4];
    assign m.wr_ch = st.chsel[1:0];
    assign m.wr_idx = acc_idx[3:0];
    assign m.wr_data = reg_wdata;
    assign m.rd_ch = st.chsel[1:0];
    assign m.rd_idx = acc_idx[3:0];
    assign m.row_ch = st.row_ch;

    // ==================== Next-state logic
    always_comb begin
        logic [1:0] c;
        logic [1:0] pick;
        logic found;
        logic fld_on;
        logic ok;
        logic valid;
        logic ng;
        logic [3:0] nib;
        logic [3:0] tol;
        logic [14:0] err;
        cdrl_row_t r;
        c = st.mch;
        pick = 2'h0;
        found = 1'b0;
        r = m.row;
        nib = r[`CDRL_IDX_RATE][`CDRL_RATE_NIB];
        // false-lock check only when enabled and reference mode 3
        fld_on = !r[`CDRL_IDX_RATE][`CDRL_RATE_FLD_OFF]
            && r[`CDRL_IDX_REF][`CDRL_REF_MODE] == `CDRL_REF_MODE3;
        // group 0 low nibble, group 1 high nibble
        tol = st.grp[c] ? r[`CDRL_IDX_TOL][7:4] : r[`CDRL_IDX_TOL][3:0];
        err = abs_diff(st.mcount, exp_count(r, st.grp[c]));
        ok = err <= {11'h000, tol};
        valid = pll_locked[c] && (!fld_on || ok);
        ng = ~st.grp[c];
        nx = st;
        nx.tune_req = 1'b0;
        nx.rvalid = st.rd_pend;
        nx.rd_pend = reg_rd;
        nx.rd_chsel = reg_addr == `CDRL_OFF_CHSEL;
        nx.rd_bad = !acc_idx[4];
        // lock falls as soon as the loop or the channel drops out
        nx.lock = st.lock & pll_locked & ~st.hold & ~st.cal_pend;
        if (st.rd_pend) begin
            nx.rdata = st.rd_chsel ? st.chsel : (st.rd_bad ? 8'h00 : m.rd_data);
        end
        if (reg_wr && reg_addr == `CDRL_OFF_CHSEL) begin
            nx.chsel = reg_wdata;
        end
        // hold while bits are set, restart on their clearing
        if (reg_wr && reg_addr == `CDRL_OFF_CTRL) begin
            if (reg_wdata[`CDRL_CTRL_RST] == 2'h3) begin
                nx.hold[st.chsel[1:0]] = 1'b1;
            end else if (reg_wdata[`CDRL_CTRL_RST] == 2'h0 && st.hold[st.chsel[1:0]]) begin
                nx.hold[st.chsel[1:0]] = 1'b0;
                nx.cal_pend[st.chsel[1:0]] = 1'b1;
            end
        end
        // manual bit hands the boost to software
        if (reg_wr && reg_addr == `CDRL_OFF_EQCTL) begin
            nx.eq_auto[st.chsel[1:0]] = !reg_wdata[`CDRL_EQ_MANUAL];
        end
        if (reg_wr && reg_addr == `CDRL_OFF_EQMAN && !nx.eq_auto[st.chsel[1:0]]) begin
            nx.eq[st.chsel[1:0]] = reg_wdata;
        end
        if (eq_adj_valid && st.eq_auto[eq_adj_ch]) begin
            nx.eq[eq_adj_ch] = eq_step(st.eq[eq_adj_ch], eq_adj_up);
        end
        for (int i = 3; i >= 0; i--) begin
            if (st.cal_pend[i] && !st.hold[i]) begin
                pick = 2'(i);
                found = 1'b1;
            end
        end
        case (st.fsm)
            ST_IDLE: begin
                if (meas_valid) begin
                    nx.mch = meas_ch;
                    nx.row_ch = meas_ch;
                    nx.mcount = meas_count;
                    nx.fsm = ST_FETCH;
                end else if (found) begin
                    nx.mch = pick;
                    nx.row_ch = pick;
                    nx.fsm = ST_CFETCH;
                end
            end
            ST_FETCH: nx.fsm = ST_EVAL;
            ST_EVAL: begin
                nx.fsm = ST_IDLE;
                if (!st.hold[c] && !st.cal_pend[c]) begin
                    // lock declared on loop lock, and on a matching count only when the false-lock check is on
                    nx.lock[c] = valid;
                    if (valid) begin
                        nx.fail[c] = 3'h0;
                    end else if (st.fail[c] + 3'h1 == `CDRL_FAIL_LIMIT) begin
                        nx.fail[c] = 3'h0;
                        nx.cal_pend[c] = 1'b1;
                    end else begin
                        // alternate groups, stepping the divider on return to group 0 or for rate nibble F
                        nx.fail[c] = st.fail[c] + 3'h1;
                        nx.grp[c] = ng;
                        if (nib == 4'hF || !ng) begin
                            nx.div[c] = sel_div(r, ng, st.div[c]);
                        end
                    end
                end
            end
            ST_CFETCH: nx.fsm = ST_CINIT;
            ST_CINIT: begin
                // search window chosen by the rate nibble
                nx.code = cap_base(nib);
                nx.last = (div_mask(nib, 1'b0) != 4'h0) ? cap_base(nib) + `CDRL_CAP_SPAN
                    : `CDRL_CAP_LAST;
                nx.best_err = `CDRL_ERR_MAX;
                nx.best_code = cap_base(nib);
                nx.grp[c] = 1'b0;
                nx.div[c] = sel_div(r, 1'b0, 2'h3);
                nx.fsm = ST_CREQ;
            end
            ST_CREQ: begin
                nx.tune_req = 1'b1;
                nx.fsm = ST_CWAIT;
            end
            ST_CWAIT: begin
                if (meas_valid && meas_ch == c) begin
                    // keep the code closest to the expected count
                    err = abs_diff(meas_count, exp_count(r, st.grp[c]));
                    if (err < st.best_err) begin
                        nx.best_err = err;
                        nx.best_code = st.code;
                    end
                    if (st.code == st.last) begin
                        nx.cap[c] = (err < st.best_err) ? st.code : st.best_code;
                        nx.cal_pend[c] = 1'b0;
                        nx.fail[c] = 3'h0;
                        nx.fsm = ST_IDLE;
                    end else begin
                        nx.code = st.code + 5'h01;
                        nx.fsm = ST_CREQ;
                    end
                end
            end
            default: nx.fsm = ST_IDLE;
        endcase
        // Divider of the channel on the tuning port, kept in a flop
        nx.tdiv = nx.div[nx.mch];
    end

    // ==================== State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= ST_RST;
        end else begin
            st <= nx;
        end
    end

    // ==================== Outputs
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign tune_req = st.tune_req;
    assign tune_ch = st.mch;
    assign tune_code = st.code;
    assign tune_div = st.tdiv;
    assign div_sel = st.div;
    assign cap_code = st.cap;
    assign eq_boost = st.eq;
    assign lock = st.lock;

    // ==================== Checks
    // Lock condition and divider set seen by the checks below
    logic fld_on_w;
    logic ok_w;
    logic [3:0] chk_mask;
    assign fld_on_w = !m.row[1][1] && m.row[2][5:4] == 2'h3;
    assign ok_w = abs_diff(st.mcount, exp_count(m.row, st.grp[st.mch]))
        <= {11'h000, st.grp[st.mch] ? m.row[7][7:4] : m.row[7][3:0]};
    assign chk_mask = div_mask(m.row[1][7:4], 1'b0);
    read_answer_a: assert property (@(posedge mclk) disable iff (rst)
        reg_rd |-> ##2 reg_rvalid) else $error("read not answered after two cycles");
    lock_follows_pll_a: assert property (@(posedge mclk) disable iff (rst)
        !pll_locked[0] |=> !lock[0]) else $error("lock kept without loop lock");
    cdr_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (reg_wr && reg_addr == `CDRL_OFF_CTRL && reg_wdata[3:2] == 2'h3)
        |-> ##2 !lock[$past(st.chsel[1:0], 2)]) else $error("lock during CDR reset");
    reset_recal_a: assert property (@(posedge mclk) disable iff (rst)
        (reg_wr && reg_addr == `CDRL_OFF_CTRL && reg_wdata[3:2] == 2'h0
        && st.hold[st.chsel[1:0]]) |=> st.cal_pend[$past(st.chsel[1:0])])
        else $error("CDR reset release did not start calibration");
    tune_window_a: assert property (@(posedge mclk) disable iff (rst)
        (tune_req && div_mask(m.row[1][7:4], 1'b0) != 4'h0)
        |-> tune_code >= cap_base(m.row[1][7:4])
        && tune_code <= cap_base(m.row[1][7:4]) + `CDRL_CAP_SPAN)
        else $error("coarse code outside window");
    div_in_set_a: assert property (@(posedge mclk) disable iff (rst)
        (tune_req && chk_mask != 4'h0)
        |-> chk_mask[tune_div]) else $error("divider not in set");
    false_lock_a: assert property (@(posedge mclk) disable iff (rst)
        (st.fsm == ST_EVAL && fld_on_w && !ok_w) |=> !lock[$past(st.mch)])
        else $error("lock declared with count out of tolerance");
    fail_recal_a: assert property (@(posedge mclk) disable iff (rst)
        (st.fsm == ST_EVAL && !st.hold[st.mch] && !st.cal_pend[st.mch]
        && st.fail[st.mch] == 3'h3 && !pll_locked[st.mch]) |=> st.cal_pend[$past(st.mch)])
        else $error("no recalibration after four failures");
    eq_adapt_a: assert property (@(posedge mclk) disable iff (rst)
        (eq_adj_valid && eq_adj_up && st.eq_auto[eq_adj_ch] && eq_boost[eq_adj_ch] != 8'hFF)
        |=> eq_boost[$past(eq_adj_ch)] != $past(eq_boost[eq_adj_ch]))
        else $error("automatic boost did not step");
    lock_rise_c: cover property (@(posedge mclk) disable iff (rst) $rose(lock[0]));
    cal_done_c: cover property (@(posedge mclk) disable iff (rst) $fell(st.cal_pend[0]));
    enet_div_c: cover property (@(posedge mclk) disable iff (rst) tune_req && tune_div == 2'h3);
endmodule : cdrl_top
`default_nettype wire

// ### dv/cdrl_osc_model.sv
// Oscillator counter model answering calibration steps and lock checks
`timescale 1ns/1ns
`default_nettype none
module cdrl_osc_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tune_req,
    input wire logic [1:0] tune_ch,
    input wire logic [4:0] tune_code,
    input wire logic chk,
    input wire logic [1:0] chk_ch,
    input wire logic [14:0] chk_cnt,
    output logic meas_valid,
    output logic [1:0] meas_ch,
    output logic [14:0] meas_count
);
    // ====================
    // reference count
    // Count rises by 32 per coarse code, so one code is closest
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meas_valid <= 1'b0;
            meas_ch <= 2'h0;
            meas_count <= 15'h0;
        end else begin
            meas_valid <= tune_req | chk;
            meas_ch <= tune_req ? tune_ch : chk_ch;
            meas_count <= tune_req ? {5'h0C, tune_code, 5'h00} : chk_cnt;
        end
    end
endmodule : cdrl_osc_model
`default_nettype wire

// ### dv/testbench.sv
// Register and lock scenarios for the rate/lock block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import cdrl_pkg::*;
    logic mclk, rst, wr, rd, chk, mv, eqv, eup;
    logic [7:0] ad, wd, rdat;
    logic rv, treq;
    logic [3:0] pll, lock;
    logic [1:0] mch, tch, tdv, cch, ech;
    logic [4:0] tcd;
    logic [14:0] mct, ccnt;
    logic [3:0][1:0] dsel;
    logic [3:0][4:0] cap;
    logic [3:0][7:0] eqb;
    int bad_count = 0;
    int comparisons = 0;
    cdrl_top i_dut (.mclk(mclk), .rst(rst), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv), .pll_locked(pll), .meas_valid(mv),
        .meas_ch(mch), .meas_count(mct), .eq_adj_valid(eqv), .eq_adj_ch(ech),
        .eq_adj_up(eup), .tune_req(treq), .tune_ch(tch), .tune_code(tcd), .tune_div(tdv),
        .div_sel(dsel), .cap_code(cap), .eq_boost(eqb), .lock(lock));
    cdrl_osc_model i_osc (.mclk(mclk), .rst(rst), .tune_req(treq), .tune_ch(tch),
        .tune_code(tcd), .chk(chk), .chk_ch(cch), .chk_cnt(ccnt), .meas_valid(mv),
        .meas_ch(mch), .meas_count(mct));
    // Clock
    always #5 mclk = ~mclk;
    task give_verdict;
        $display("compares %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task check(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, s, e);
        end
    endtask : check
    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 ad = a; wd = d; wr = 1'b1;
        @(posedge mclk);
        #1 wr = 1'b0;
    endtask : wreg
    task rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        #1 ad = a; rd = 1'b1;
        @(posedge mclk);
        #1 rd = 1'b0;
        for (int i = 0; i < 4 && rv !== 1'b1; i++) @(posedge mclk) #1;
        check(rv, 1'b1);
        check(rdat, e);
    endtask : rreg
    task meas(input logic [1:0] c, input logic [14:0] n, input logic e);
        @(posedge mclk);
        #1 chk = 1'b1; cch = c; ccnt = n;
        @(posedge mclk);
        #1 chk = 1'b0;
        repeat (5) @(posedge mclk);
        #1 check(lock[c], e);
    endtask : meas
    task eqadj(input logic [1:0] c, input logic u, input logic [7:0] e);
        @(posedge mclk);
        #1 eqv = 1'b1; ech = c; eup = u;
        @(posedge mclk);
        #1 eqv = 1'b0;
        check(eqb[c], e);
    endtask : eqadj
    // Watchdog
    initial begin
        repeat (6000) @(posedge mclk);
        bad_count++;
        give_verdict();
    end
    // Main sequence
    initial begin
        mclk = 0; rst = 1; wr = 0; rd = 0; chk = 0; eqv = 0;
        ad = 0; wd = 0; pll = 4'hF; cch = 0; ccnt = 0; ech = 0; eup = 0;
        repeat (20) @(posedge mclk);
        #1 rst = 0;
        rreg(8'h2F, 8'h02);
        rreg(8'h36, 8'h30);
        rreg(8'h10, 8'h00);
        repeat (1200) @(posedge mclk);
        #1 check(cap[1], 5'h10);
        check(dsel[1], 2'h0);
        $display("test reset and calibration done");
        wreg(8'hFF, 8'h01);
        wreg(8'h60, 8'hA5);
        rreg(8'h60, 8'hA5);
        wreg(8'hFF, 8'h00);
        rreg(8'h60, 8'h00);
        $display("test channel select done");
        meas(2'h0, 15'h0, 1'b1);
        wreg(8'h36, 8'h30);
        wreg(8'h2F, 8'hC4);
        wreg(8'h60, 8'h90);
        wreg(8'h61, 8'hB3);
        wreg(8'h62, 8'h90);
        wreg(8'h63, 8'hB3);
        wreg(8'h64, 8'h22);
        rreg(8'h63, 8'hB3);
        wreg(8'h0A, 8'h0C);
        repeat (3) @(posedge mclk);
        #1 check(lock[0], 1'b0);
        wreg(8'h0A, 8'h00);
        repeat (400) @(posedge mclk);
        #1 check(cap[0], 5'h13);
        check(dsel[0], 2'h0);
        meas(2'h0, 15'h3392, 1'b1);
        meas(2'h0, 15'h3393, 1'b0);
        pll = 4'h0;
        repeat (3) meas(2'h0, 15'h3390, 1'b0);
        repeat (60) @(posedge mclk);
        #1 pll = 4'hF;
        meas(2'h0, 15'h3390, 1'b1);
        wreg(8'h64, 8'hFF);
        meas(2'h0, 15'h339F, 1'b1);
        $display("test lock check done");
        eqadj(2'h2, 1'b1, 8'h01);
        eqadj(2'h2, 1'b1, 8'h02);
        eqadj(2'h2, 1'b0, 8'h01);
        wreg(8'hFF, 8'h02);
        wreg(8'h2D, 8'h01);
        eqadj(2'h2, 1'b1, 8'h01);
        wreg(8'h2C, 8'hE4);
        check(eqb[2], 8'hE4);
        $display("test equalizer done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
